// ---- src/poc_phy_option_config.sv ----
// Purpose: phy option configuration register and the datapath hooks it steers
// Assumes: i_clk is the mii clock; register port and line data are synchronous to it
// Notes: encoders, scrambler, jabber timer and energy detector live outside
//
// Contract
// - noise hardened carrier mode bit, reset zero
// - in hardened mode carrier needs energy and valid manchester, else energy alone
// - unjab bit enables automatic jabber recovery
// - bypass bit sends transmit nibbles unscrambled
// - bypass bit skips receive descrambling
// - unmask bit keeps collision detect, reset one
// - delay bit adds fourteen cycle receive delay
// - register is sixteen bits wide
module poc_phy_option_config
   import poc_pkg::*;
#(
   parameter int DLY = POC_RX_DLY_CYC
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_hit,
   // carrier qualification
   input wire logic i_energy_det,
   input wire logic i_manchester_ok,
   output logic o_carrier,
   // jabber recovery
   input wire logic i_jabber_active,
   input wire logic i_unjab_expired,
   output logic o_jabber_recover,
   // transmit nibbles
   input wire logic [3:0] i_tx_plain,
   input wire logic [3:0] i_tx_scrambled,
   output logic [3:0] o_tx_nibble,
   // receive nibbles
   input wire logic [3:0] i_rx_raw,
   input wire logic [3:0] i_rx_descrambled,
   input wire logic i_rx_valid,
   output logic [3:0] o_rx_data,
   output logic o_rx_valid,
   // collision
   input wire logic i_col_phys,
   output logic o_col,
   // mode flags
   output logic o_noise_hardened_carrier_mode,
   output logic o_scr_bypass
);
   // ==========================================================
   // configuration register
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] rdata_q, rdata_d;
   logic hit;

   assign hit = (i_reg_addr == POC_ADDR);
   assign o_reg_hit = hit;

   // next register value: only writable bits take the write
   always_comb
   begin
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      if (i_reg_wr && hit)
      begin
         cfg_d = i_reg_wdata & POC_WR_MASK;
      end
      if (i_reg_rd)
      begin
         // unmapped addresses read zero
         rdata_d = hit ? (cfg_q & POC_WR_MASK) : 16'h0000;
      end
   end

   // register stage
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cfg_q <= POC_RESET;
         rdata_q <= 16'h0000;
      end
      else
      begin
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
      end
   end
   assign o_reg_rdata = rdata_q;

   // field decode
   logic nhc, unjab, byp, unmask, rxdly;
   assign nhc = cfg_q[POC_BIT_NHC];
   assign unjab = cfg_q[POC_BIT_UNJAB];
   assign byp = cfg_q[POC_BIT_SCR_BYP];
   assign unmask = cfg_q[POC_BIT_COL_UNMASK];
   assign rxdly = cfg_q[POC_BIT_RX_DLY];
   assign o_noise_hardened_carrier_mode = nhc;
   assign o_scr_bypass = byp;

   // ==========================================================
   // datapath flops: carrier, recovery, collision, tx nibble
   logic car_q, car_d, rec_q, rec_d, col_q, col_d;
   logic [3:0] tx_q, tx_d;

   // qualification and selection
   always_comb
   begin
      // noise alone must not look like carrier in hardened mode
      car_d = nhc ? (i_energy_det && i_manchester_ok) : i_energy_det;
      rec_d = unjab && i_unjab_expired && !i_jabber_active;
      col_d = i_col_phys && (!nhc || unmask);
      tx_d = byp ? i_tx_plain : i_tx_scrambled;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         car_q <= 1'b0;
         rec_q <= 1'b0;
         col_q <= 1'b0;
         tx_q <= 4'h0;
      end
      else
      begin
         car_q <= car_d;
         rec_q <= rec_d;
         col_q <= col_d;
         tx_q <= tx_d;
      end
   end
   assign o_carrier = car_q;
   assign o_jabber_recover = rec_q;
   assign o_col = col_q;
   assign o_tx_nibble = tx_q;

   // ==========================================================
   // receive path: select, then optional fixed delay line
   // a shift line costs a few flops but keeps latency exact
   logic [4:0] sel;
   logic [4:0] dl_q [DLY];
   logic [4:0] dl_d [DLY];
   logic [4:0] out_q, out_d;

   assign sel = {i_rx_valid, byp ? i_rx_raw : i_rx_descrambled};

   // shift line next values and output mux
   always_comb
   begin
      dl_d[0] = sel;
      for (int k = 1; k < DLY; k++)
      begin
         dl_d[k] = dl_q[k-1];
      end
      // delay line tap when enabled, else direct
      out_d = rxdly ? dl_q[DLY-1] : sel;
   end

   genvar g;
   generate
      for (g = 0; g < DLY; g++)
      begin : g_dly
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
            begin
               dl_q[g] <= 5'h00;
            end
            else
            begin
               dl_q[g] <= dl_d[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         out_q <= 5'h00;
      end
      else
      begin
         out_q <= out_d;
      end
   end
   assign o_rx_data = out_q[3:0];
   assign o_rx_valid = out_q[4];

   // ==========================================================
   // checks
   a_cfg_reset_val: assert property (@(posedge i_clk) $fell(i_rst) |-> cfg_q == POC_RESET)
      else $error("config reset value wrong");
   a_unused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_q & ~POC_WR_MASK) == 16'h0000)
      else $error("unused config bits set");
   a_write_takes: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_reg_wr && hit) |=> cfg_q == ($past(i_reg_wdata) & POC_WR_MASK))
      else $error("config write lost");
   a_carrier_qual: assert property (@(posedge i_clk) disable iff (i_rst)
      (nhc && !i_manchester_ok) |=> !o_carrier)
      else $error("carrier taken without manchester");
   a_jab_recover: assert property (@(posedge i_clk) disable iff (i_rst)
      o_jabber_recover |-> $past(unjab) && !$past(i_jabber_active))
      else $error("jabber recovery while disabled");
   a_tx_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
      byp |=> o_tx_nibble == $past(i_tx_plain))
      else $error("tx nibble scrambled in bypass");
   a_rx_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
      (byp && !rxdly) |=> o_rx_data == $past(i_rx_raw))
      else $error("rx data descrambled in bypass");
   a_col_mask: assert property (@(posedge i_clk) disable iff (i_rst)
      (nhc && !unmask) |=> !o_col)
      else $error("collision not masked");
   a_rx_delay: assert property (@(posedge i_clk) disable iff (i_rst)
      (rxdly && !i_reg_wr) [*8] ##1 rxdly[*7] |=> o_rx_valid == $past(i_rx_valid, 15)
      && o_rx_data == ($past(byp, 15) ? $past(i_rx_raw, 15)
      : $past(i_rx_descrambled, 15)))
      else $error("rx delay not fourteen cycles");
endmodule : poc_phy_option_config

// ---- inc/poc_pkg.sv ----
// Purpose: constants for the phy option configuration register
// Assumes: register reached through the vendor register map port, 16-bit data
// Notes: one register, fields listed by bit position
package poc_pkg;
   // ==========================================================
   // register map
   localparam logic [15:0] POC_ADDR = 16'h8001; // vendor_memory_map_four offset
   localparam int POC_WIDTH = 16;
   // ==========================================================
   // field positions
   localparam int POC_BIT_RSVD = 15;
   localparam int POC_BIT_NHC = 7;
   localparam int POC_BIT_UNJAB = 6;
   localparam int POC_BIT_SCR_BYP = 2;
   localparam int POC_BIT_COL_UNMASK = 1;
   localparam int POC_BIT_RX_DLY = 0;
   // writable bits and reset value
   localparam logic [15:0] POC_WR_MASK = 16'h80C7;
   localparam logic [15:0] POC_RESET = 16'h0003;
   // ==========================================================
   // receive delay in mii clock cycles
   localparam int POC_RX_DLY_CYC = 14;
endpackage : poc_pkg

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the phy option configuration register
// Assumes: one mii clock; inputs driven by nba on the rising edge
// Notes: datapath swept over all sixteen values of a four-bit input vector per config value
module tb
   import poc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus and observed signals
   logic i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [15:0] i_reg_addr = 16'h0000, i_reg_wdata = 16'h0000, o_reg_rdata;
   logic i_energy_det = 1'b0, i_manchester_ok = 1'b0, i_jabber_active = 1'b0;
   logic i_unjab_expired = 1'b0, i_rx_valid = 1'b0, i_col_phys = 1'b0;
   logic [3:0] i_tx_plain = 4'hA, i_tx_scrambled = 4'h5, i_rx_raw = 4'hC;
   logic [3:0] i_rx_descrambled = 4'h3, o_tx_nibble, o_rx_data;
   logic o_reg_hit, o_carrier, o_jabber_recover, o_rx_valid, o_col, o_nhc, o_byp;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   poc_phy_option_config u_poc_phy_option_config (.i_clk, .i_rst, .i_reg_wr,
      .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .i_energy_det,
      .i_manchester_ok, .o_carrier, .i_jabber_active, .i_unjab_expired,
      .o_jabber_recover, .i_tx_plain, .i_tx_scrambled, .o_tx_nibble, .i_rx_raw,
      .i_rx_descrambled, .i_rx_valid, .o_rx_data, .o_rx_valid, .i_col_phys, .o_col,
      .o_noise_hardened_carrier_mode(o_nhc), .o_scr_bypass(o_byp));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // one-cycle write strobe; config lands on the closing edge
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : wr
   // read data is registered, looked at after the closing edge
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1;
      chk(o_reg_rdata, exp);
      chk(16'(o_reg_hit), 16'(a == POC_ADDR));
   endtask : rd
   // ==========================================================
   // scenarios
   task automatic t_regs();
      rd(POC_ADDR, 16'h0003);
      chk(16'({o_nhc, o_byp}), 16'h0000);
      wr(POC_ADDR, 16'hFFFF);
      rd(POC_ADDR, 16'h80C7);
      wr(16'h8002, 16'h0000); // unmapped place must not alias
      rd(POC_ADDR, 16'h80C7);
      rd(16'h8002, 16'h0000);
      wr(POC_ADDR, 16'h0000);
      rd(POC_ADDR, 16'h0000);
   endtask : t_regs
   // sweep inputs; delay bit kept clear so outputs follow in one cycle
   task automatic t_path(input logic [15:0] c);
      logic [3:0] v;
      wr(POC_ADDR, c);
      for (int i = 0; i < 16; i++)
      begin
         v = 4'(i);
         @(posedge i_clk);
         {i_unjab_expired, i_jabber_active, i_manchester_ok, i_energy_det} <= v;
         i_col_phys <= v[0] ^ v[1];
         i_rx_valid <= v[2];
         // nibbles follow the sweep so the selected source is visible
         i_tx_plain <= v;
         i_tx_scrambled <= v ^ 4'hF;
         i_rx_raw <= v ^ 4'hC;
         i_rx_descrambled <= v ^ 4'h3;
         @(posedge i_clk);
         #1;
         chk(16'(o_carrier), 16'(v[0] & (v[1] | !c[7])));
         chk(16'(o_jabber_recover), 16'(c[6] & v[3] & !v[2]));
         chk(16'(o_col), 16'((v[0] ^ v[1]) & (!c[7] | c[1])));
         chk(16'(o_tx_nibble), 16'(c[2] ? v : v ^ 4'hF));
         chk(16'({o_nhc, o_byp}), 16'({c[7], c[2]}));
         chk(16'(o_rx_valid), 16'(v[2]));
         if (v[2])
            chk(16'(o_rx_data), 16'(c[2] ? v ^ 4'hC : v ^ 4'h3));
      end
   endtask : t_path
   // single receive pulse; count cycles until it comes out
   task automatic t_delay(input logic [15:0] c, input int n);
      int k;
      wr(POC_ADDR, c);
      i_rx_valid <= 1'b0;
      repeat (20) @(posedge i_clk); // flush anything still in the delay line
      i_rx_valid <= 1'b1;
      i_rx_raw <= 4'hC;
      i_rx_descrambled <= 4'h3;
      @(posedge i_clk);
      // other data after the pulse, so data must travel with valid
      i_rx_valid <= 1'b0;
      i_rx_raw <= 4'h0;
      i_rx_descrambled <= 4'h0;
      #1;
      k = 1;
      while (o_rx_valid !== 1'b1 && k < 40)
      begin
         @(posedge i_clk);
         #1;
         k++;
      end
      chk(16'(k), 16'(n));
      chk(16'(o_rx_data), 16'(c[2] ? 4'hC : 4'h3));
   endtask : t_delay
   // mid-run reset must bring back the default of every field
   task automatic t_reset();
      wr(POC_ADDR, 16'h80C4);
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(POC_ADDR, POC_RESET);
      chk(16'({o_nhc, o_byp}), 16'h0000);
   endtask : t_reset
   // ==========================================================
   // clock, watchdog, main sequence
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_path(16'h0000);
      t_path(16'h0080);
      t_path(16'h0082);
      t_path(16'h0046);
      t_path(16'h0004);
      t_delay(16'h0001, POC_RX_DLY_CYC + 1);
      t_delay(16'h0004, 1);
      t_delay(16'h0005, POC_RX_DLY_CYC + 1);
      t_reset();
      wrap_up();
   end
endmodule : tb
